// >>> tx_ohsel_pkg.sv
// constants, types and register map of the transmit overhead select block
// assumes a byte-wide transmit stream tagged with its overhead slot
package tx_ohsel_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;

  localparam logic [ADDR_W-1:0] OFF_SRC  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_ALM  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_INS  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_DCC  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_FEBE = 8'h14;

  // source control register bits
  localparam int B_SPE_ONLY  = 0;
  localparam int B_LDCC_INS  = 1;
  localparam int B_LDCC_EXT  = 2;
  localparam int B_LDCC_PORT = 3;
  localparam int B_ALL_OH    = 4;
  localparam int B_Z1_INS    = 5;
  localparam int B_Z1_EXT    = 6;
  localparam int B_Z2_INS    = 7;
  localparam int B_Z2_EXT    = 8;
  localparam int B_E2_INS    = 9;
  localparam int B_E2_EXT    = 10;
  localparam int B_E1_INS    = 11;
  localparam int B_E1_EXT    = 12;
  localparam int SRC_W       = 13;

  // alarm control register bits
  localparam int B_FEBE_EN   = 0;
  localparam int B_RING_SEL  = 1;
  localparam int B_E1_ALM    = 2;
  localparam int B_AIS_EN    = 3;
  localparam int B_PTE       = 4;
  localparam int B_LTE       = 5;
  localparam int B_FRC_PAIS  = 6;
  localparam int B_FIFO_REC  = 7;
  localparam int B_AUTO_PAIS = 8;
  localparam int B_TE1_TRIG  = 9;
  localparam int B_FRC_LRDI  = 10;
  localparam int B_AUTO_LRDI = 11;
  localparam int B_B2_TRIG   = 12;
  localparam int B_J0_TRIG   = 13;
  localparam int B_FRC_LAIS  = 14;
  localparam int B_AUTO_LAIS = 15;
  localparam int ALM_W       = 16;

  // status register bits
  localparam int B_ST_LAISC = 0;
  localparam int B_ST_PAISC = 1;
  localparam int B_ST_PAIS  = 2;
  localparam int B_ST_LAIS  = 3;
  localparam int B_ST_LRDI  = 4;

  localparam logic [SRC_W-1:0]  RST_SRC = 13'h0000;
  localparam logic [ALM_W-1:0]  RST_ALM = 16'h0000;
  localparam logic [31:0]       RST_INS = 32'h0000_0000;
  localparam logic [7:0]        RST_DCC = 8'h00;

  localparam logic [3:0] NDF_ACTIVE   = 4'h9;
  localparam logic [3:0] NDF_INACTIVE = 4'h6;
  localparam logic [2:0] LRDI_CODE    = 3'h6;
  localparam logic [3:0] FEBE_MAX     = 4'h8;
  localparam int         ACC_W        = 8;

  typedef enum logic [3:0] {
    K_SOH   = 4'h0,
    K_LDCC  = 4'h1,
    K_Z1    = 4'h2,
    K_Z2    = 4'h3,
    K_E2    = 4'h4,
    K_E1    = 4'h5,
    K_K2    = 4'h6,
    K_H1    = 4'h7,
    K_H2    = 4'h8,
    K_H3    = 4'h9,
    K_SPE   = 4'ha,
    K_LOH   = 4'hb
  } slot_t;

  typedef enum logic [1:0] {
    SRC_TERM = 2'h0,
    SRC_CPU  = 2'h1,
    SRC_EXT  = 2'h2
  } src_t;

  typedef struct packed {
    logic        valid;
    slot_t       kind;
    logic [7:0]  data;
  } tx_slot_t;

endpackage

// >>> tx_far_err_accum.sv
// far-end block error accumulator between receive and transmit rates
// assumes add and take strobes on the block clock
`timescale 1ns/1ns
`default_nettype none
module tx_far_err_accum (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_add_valid,
  input  wire logic [3:0] i_add_count,
  input  wire logic       i_take,
  output logic      [3:0] o_count
);
  logic [tx_ohsel_pkg::ACC_W-1:0] acc;
  logic [tx_ohsel_pkg::ACC_W:0]   sum;
  logic [tx_ohsel_pkg::ACC_W-1:0] next_acc;
  logic [3:0]                     add;
  logic [3:0]                     take;

  assign o_count = (acc > tx_ohsel_pkg::ACC_W'(tx_ohsel_pkg::FEBE_MAX)) ?
                   tx_ohsel_pkg::FEBE_MAX : acc[3:0];
  assign add  = i_add_valid ? i_add_count : 4'h0;
  assign take = i_take ? o_count : 4'h0;
  assign sum  = {1'b0, acc} + {5'h00, add} - {5'h00, take};
  // saturate rather than wrap, losing counts only past full scale
  assign next_acc = sum[tx_ohsel_pkg::ACC_W] ? '1 :
                    sum[tx_ohsel_pkg::ACC_W-1:0];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      acc <= '0;
    end else begin
      acc <= next_acc;
    end
  end
endmodule
`default_nettype wire

// >>> tx_overhead_select_alarm_insert.sv
// transmit overhead byte selection with ais, rdi and far-end error insert
// assumes a tagged byte stream on i_clk and an apb master for control
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module tx_overhead_select_alarm_insert (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [7:0]             i_paddr,
  input  wire logic [31:0]            i_pwdata,
  output logic      [31:0]            o_prdata,
  output logic                        o_pready,
  output logic                        o_pslverr,
  input  wire tx_ohsel_pkg::tx_slot_t i_term,
  input  wire logic [7:0]             i_ext_line_dcc,
  input  wire logic [7:0]             i_ext_toh,
  input  wire logic                   i_alarm_input_pin_n,
  input  wire logic                   i_terminal_alarm,
  input  wire logic                   i_terminal_e1_alarm,
  input  wire logic                   i_fifo_error,
  input  wire logic                   i_rx_line_anomaly,
  input  wire logic                   i_excess_b2_error_rate,
  input  wire logic                   i_section_trace_mismatch,
  input  wire logic                   i_ring_rdi_req,
  input  wire logic                   i_b2_err_valid,
  input  wire logic [3:0]             i_b2_err_count,
  input  wire logic                   i_ring_febe_valid,
  input  wire logic [3:0]             i_ring_febe_count,
  output tx_ohsel_pkg::tx_slot_t      o_line
);

  function automatic tx_ohsel_pkg::src_t pick(input logic spe,
                                              input logic ins,
                                              input logic ext,
                                              input logic ext_block);
    if (!(spe || ins)) begin
      pick = tx_ohsel_pkg::SRC_TERM;
    end else if (ext && !ext_block) begin
      pick = tx_ohsel_pkg::SRC_EXT;
    end else begin
      pick = tx_ohsel_pkg::SRC_CPU;
    end
  endfunction

  function automatic logic [7:0] mux3(input tx_ohsel_pkg::src_t s,
                                      input logic [7:0] t,
                                      input logic [7:0] c,
                                      input logic [7:0] e);
    unique case (s)
      tx_ohsel_pkg::SRC_CPU: mux3 = c;
      tx_ohsel_pkg::SRC_EXT: mux3 = e;
      default:               mux3 = t;
    endcase
  endfunction

  logic [tx_ohsel_pkg::SRC_W-1:0] src_ctrl;
  logic [tx_ohsel_pkg::ALM_W-1:0] alm_ctrl;
  logic [31:0]                    ins_bytes;
  logic [7:0]                     dcc_byte;
  logic                           alarm_meta;
  logic                           alarm_sync;
  logic                           ais_at_h1;
  logic [31:0]                    next_prdata;
  logic [7:0]                     sel_byte;
  logic [7:0]                     next_byte;
  logic [3:0]                     febe_count;

  // apb decode
  wire setup    = i_psel && !i_penable;
  wire wr_en    = i_psel && i_penable && i_pwrite;
  wire hit_src  = i_paddr == tx_ohsel_pkg::OFF_SRC;
  wire hit_alm  = i_paddr == tx_ohsel_pkg::OFF_ALM;
  wire hit_ins  = i_paddr == tx_ohsel_pkg::OFF_INS;
  wire hit_dcc  = i_paddr == tx_ohsel_pkg::OFF_DCC;
  wire hit_stat = i_paddr == tx_ohsel_pkg::OFF_STAT;
  wire hit_febe = i_paddr == tx_ohsel_pkg::OFF_FEBE;
  wire hit_ro   = hit_stat || hit_febe;
  wire hit_any  = hit_src || hit_alm || hit_ins || hit_dcc || hit_ro;
  // read-only registers refuse writes
  wire bad_acc  = !hit_any || (i_pwrite && hit_ro);

  // control fields
  wire spe_only   = src_ctrl[tx_ohsel_pkg::B_SPE_ONLY];
  wire all_oh     = src_ctrl[tx_ohsel_pkg::B_ALL_OH];
  wire ldcc_port  = src_ctrl[tx_ohsel_pkg::B_LDCC_PORT];
  wire febe_en    = alm_ctrl[tx_ohsel_pkg::B_FEBE_EN];
  wire ring_sel   = alm_ctrl[tx_ohsel_pkg::B_RING_SEL];
  wire e1_alm_en  = alm_ctrl[tx_ohsel_pkg::B_E1_ALM];
  wire ais_en     = alm_ctrl[tx_ohsel_pkg::B_AIS_EN];
  wire path_terminating_mode        = alm_ctrl[tx_ohsel_pkg::B_PTE];
  wire line_terminating_mode        = alm_ctrl[tx_ohsel_pkg::B_LTE];

  // alarm pin is asynchronous; only the second stage is used
  wire alarm_low = !alarm_sync;

  wire tx_ohsel_pkg::src_t dcc_src = pick(spe_only,
      src_ctrl[tx_ohsel_pkg::B_LDCC_INS],
      src_ctrl[tx_ohsel_pkg::B_LDCC_EXT], 1'b0);
  wire [7:0] dcc_ext = (all_oh && !ldcc_port) ? i_ext_toh : i_ext_line_dcc;
  wire tx_ohsel_pkg::src_t z1_src = pick(spe_only,
      src_ctrl[tx_ohsel_pkg::B_Z1_INS],
      src_ctrl[tx_ohsel_pkg::B_Z1_EXT], all_oh);
  wire tx_ohsel_pkg::src_t z2_src = pick(spe_only,
      src_ctrl[tx_ohsel_pkg::B_Z2_INS],
      src_ctrl[tx_ohsel_pkg::B_Z2_EXT], all_oh);
  wire tx_ohsel_pkg::src_t e2_src = pick(spe_only,
      src_ctrl[tx_ohsel_pkg::B_E2_INS],
      src_ctrl[tx_ohsel_pkg::B_E2_EXT], 1'b0);
  wire tx_ohsel_pkg::src_t e1_src = pick(spe_only,
      src_ctrl[tx_ohsel_pkg::B_E1_INS],
      src_ctrl[tx_ohsel_pkg::B_E1_EXT], 1'b0);

  wire pais_fifo = i_fifo_error && alm_ctrl[tx_ohsel_pkg::B_FIFO_REC];
  wire pais_auto = alm_ctrl[tx_ohsel_pkg::B_AUTO_PAIS] &&
      (i_terminal_alarm || alarm_low ||
       (i_terminal_e1_alarm && alm_ctrl[tx_ohsel_pkg::B_TE1_TRIG]));
  wire path_ais_condition = alm_ctrl[tx_ohsel_pkg::B_FRC_PAIS] ||
      pais_fifo || pais_auto;
  wire path_ais_on = path_ais_condition && ais_en && (path_terminating_mode || line_terminating_mode);
  wire line_ais_condition = alm_ctrl[tx_ohsel_pkg::B_FRC_LAIS] ||
      (alm_ctrl[tx_ohsel_pkg::B_AUTO_LAIS] &&
       (alarm_low || i_terminal_alarm));
  wire line_ais_on = line_ais_condition && ais_en && !path_terminating_mode && !line_terminating_mode;
  wire ais_on = path_ais_on || line_ais_on;
  // e1 alarm follows the ais conditions
  wire e1_alarm = path_ais_condition || line_ais_condition;
  wire rdi_auto = alm_ctrl[tx_ohsel_pkg::B_AUTO_LRDI] &&
      (i_rx_line_anomaly ||
       (i_excess_b2_error_rate && alm_ctrl[tx_ohsel_pkg::B_B2_TRIG]) ||
       (i_section_trace_mismatch && alm_ctrl[tx_ohsel_pkg::B_J0_TRIG]));
  wire line_rdi_on = alm_ctrl[tx_ohsel_pkg::B_FRC_LRDI] ||
      i_ring_rdi_req || rdi_auto;

  wire is_h1    = i_term.valid && i_term.kind == tx_ohsel_pkg::K_H1;
  wire take_z2  = i_term.valid && i_term.kind == tx_ohsel_pkg::K_Z2 &&
                  febe_en;
  // section bytes sit above the line level and survive line ais
  wire line_lvl = i_term.kind != tx_ohsel_pkg::K_SOH &&
                  i_term.kind != tx_ohsel_pkg::K_E1;
  wire path_lvl = i_term.kind == tx_ohsel_pkg::K_H1 ||
                  i_term.kind == tx_ohsel_pkg::K_H2 ||
                  i_term.kind == tx_ohsel_pkg::K_H3 ||
                  i_term.kind == tx_ohsel_pkg::K_SPE;

  wire       febe_add_v = ring_sel ? i_ring_febe_valid : i_b2_err_valid;
  wire [3:0] febe_add_c = ring_sel ? i_ring_febe_count : i_b2_err_count;

  tx_far_err_accum u_accum (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_add_valid (febe_add_v),
    .i_add_count (febe_add_c),
    .i_take      (take_z2),
    .o_count     (febe_count)
  );

  // normal source selection first
  always_comb begin
    sel_byte = i_term.data;
    unique case (i_term.kind)
      tx_ohsel_pkg::K_LDCC:
        sel_byte = mux3(dcc_src, i_term.data, dcc_byte, dcc_ext);
      tx_ohsel_pkg::K_Z1:
        sel_byte = mux3(z1_src, i_term.data, ins_bytes[7:0], i_ext_toh);
      tx_ohsel_pkg::K_Z2:
        sel_byte = mux3(z2_src, i_term.data, ins_bytes[15:8], i_ext_toh);
      tx_ohsel_pkg::K_E2:
        sel_byte = mux3(e2_src, i_term.data, ins_bytes[23:16], i_ext_toh);
      tx_ohsel_pkg::K_E1:
        sel_byte = mux3(e1_src, i_term.data, ins_bytes[31:24], i_ext_toh);
      tx_ohsel_pkg::K_SOH, tx_ohsel_pkg::K_K2, tx_ohsel_pkg::K_H1,
      tx_ohsel_pkg::K_H2, tx_ohsel_pkg::K_H3, tx_ohsel_pkg::K_SPE,
      tx_ohsel_pkg::K_LOH:
        sel_byte = i_term.data;
      default:
        sel_byte = i_term.data;
    endcase
  end

  always_comb begin
    next_byte = sel_byte;
    if (i_term.kind == tx_ohsel_pkg::K_Z2 && febe_en) begin
      next_byte[3:0] = febe_count;
    end
    if (i_term.kind == tx_ohsel_pkg::K_E1 && e1_alm_en) begin
      next_byte = {8{e1_alarm}};
    end
    if (i_term.kind == tx_ohsel_pkg::K_K2 && line_rdi_on) begin
      next_byte[2:0] = tx_ohsel_pkg::LRDI_CODE;
    end
    if (i_term.kind == tx_ohsel_pkg::K_H1 && !ais_on) begin
      next_byte[7:4] = ais_at_h1 ? tx_ohsel_pkg::NDF_ACTIVE :
                                   tx_ohsel_pkg::NDF_INACTIVE;
    end
    if (path_ais_on && path_lvl) begin
      next_byte = 8'hff;
    end
    if (line_ais_on && line_lvl) begin
      next_byte = 8'hff;
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_src) begin
      next_prdata[tx_ohsel_pkg::SRC_W-1:0] = src_ctrl;
    end
    if (hit_alm) begin
      next_prdata[tx_ohsel_pkg::ALM_W-1:0] = alm_ctrl;
    end
    if (hit_ins) begin
      next_prdata = ins_bytes;
    end
    if (hit_dcc) begin
      next_prdata[7:0] = dcc_byte;
    end
    if (hit_stat) begin
      next_prdata[tx_ohsel_pkg::B_ST_LAISC] = line_ais_condition;
      next_prdata[tx_ohsel_pkg::B_ST_PAISC] = path_ais_condition;
      next_prdata[tx_ohsel_pkg::B_ST_PAIS]  = path_ais_on;
      next_prdata[tx_ohsel_pkg::B_ST_LAIS]  = line_ais_on;
      next_prdata[tx_ohsel_pkg::B_ST_LRDI]  = line_rdi_on;
    end
    if (hit_febe) begin
      next_prdata[3:0] = febe_count;
    end
  end

  assign o_pready = i_psel && i_penable;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (setup) begin
      o_prdata  <= i_pwrite ? 32'h0000_0000 : next_prdata;
      o_pslverr <= bad_acc;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      src_ctrl  <= tx_ohsel_pkg::RST_SRC;
      alm_ctrl  <= tx_ohsel_pkg::RST_ALM;
      ins_bytes <= tx_ohsel_pkg::RST_INS;
      dcc_byte  <= tx_ohsel_pkg::RST_DCC;
    end else if (wr_en) begin
      if (hit_src) begin
        src_ctrl <= i_pwdata[tx_ohsel_pkg::SRC_W-1:0];
      end
      if (hit_alm) begin
        alm_ctrl <= i_pwdata[tx_ohsel_pkg::ALM_W-1:0];
      end
      if (hit_ins) begin
        ins_bytes <= i_pwdata;
      end
      if (hit_dcc) begin
        dcc_byte <= i_pwdata[7:0];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      alarm_meta <= 1'b1;
      alarm_sync <= 1'b1;
    end else begin
      alarm_meta <= i_alarm_input_pin_n;
      alarm_sync <= alarm_meta;
    end
  end

  // remember ais state at each pointer
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ais_at_h1 <= 1'b0;
    end else if (is_h1) begin
      ais_at_h1 <= ais_on;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_line <= '0;
    end else begin
      o_line <= '{valid: i_term.valid, kind: i_term.kind, data: next_byte};
    end
  end

  a_line_ais_ones: assert property (
    @(posedge i_clk) disable iff (i_rst)
    line_ais_on && i_term.valid && line_lvl |=> o_line.data == 8'hff)
    else $error("line ais byte not all ones");

  a_path_ais_perm: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_term.kind == tx_ohsel_pkg::K_SPE && i_term.valid &&
    !(ais_en && (path_terminating_mode || line_terminating_mode)) && !line_ais_on && i_term.data == 8'h00
    |=> o_line.data == 8'h00)
    else $error("path ais applied without permission");

  a_path_ais_cmd: assert property (
    @(posedge i_clk) disable iff (i_rst)
    alm_ctrl[tx_ohsel_pkg::B_FRC_PAIS] && ais_en && path_terminating_mode &&
    i_term.kind == tx_ohsel_pkg::K_H3 |=> o_line.data == 8'hff)
    else $error("forced path ais missing on h3");

  a_rdi_code: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_term.kind == tx_ohsel_pkg::K_K2 && line_rdi_on && !line_ais_on
    |=> o_line.data[2:0] == 3'b110 && o_line.kind == tx_ohsel_pkg::K_K2)
    else $error("k2 rdi pattern wrong");

  a_e1_alarm: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_term.kind == tx_ohsel_pkg::K_E1 && e1_alm_en
    |=> o_line.data == {8{$past(e1_alarm)}})
    else $error("e1 alarm byte wrong");

  a_febe_nibble: assert property (
    @(posedge i_clk) disable iff (i_rst)
    take_z2 && !line_ais_on |=> o_line.data[3:0] <= 4'h8 &&
    o_line.data[3:0] == $past(febe_count))
    else $error("far-end count not in z2");

  a_z1_terminal: assert property (
    @(posedge i_clk) disable iff (i_rst)
    i_term.kind == tx_ohsel_pkg::K_Z1 && !spe_only &&
    !src_ctrl[tx_ohsel_pkg::B_Z1_INS] && !line_ais_on
    |=> o_line.data == $past(i_term.data))
    else $error("z1 not taken from terminal");

  a_ndf_after_ais: assert property (
    @(posedge i_clk) disable iff (i_rst)
    is_h1 && ais_at_h1 && !ais_on |=> o_line.data[7:4] == 4'h9)
    else $error("ndf not set after ais end");

  a_status_paisc: assert property (
    @(posedge i_clk) disable iff (i_rst)
    setup && !i_pwrite && hit_stat && alm_ctrl[tx_ohsel_pkg::B_FRC_PAIS]
    ##1 i_penable |-> o_prdata[1] && o_pready)
    else $error("path ais condition not reported");

endmodule
`default_nettype wire

// >>> tx_term_far_end.sv
// far-end model: terminal byte stream and external overhead ports
// assumes the bench picks slot kind and valid just after a rising edge
`timescale 1ns/1ns
`default_nettype none
module tx_term_far_end (
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_go,
  input  wire tx_ohsel_pkg::slot_t i_kind,
  output tx_ohsel_pkg::tx_slot_t   o_term,
  output logic [7:0]               o_ext_line_dcc,
  output logic [7:0]               o_ext_toh
);
  logic [23:0] pat;
  // ports shift every cycle; a byte repeats only when nine equal bits run through the register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst)
      pat <= 24'h5a3c96;
    else
      pat <= {pat[22:0], pat[23] ^ pat[22] ^ pat[21] ^ pat[16]};
  end
  assign o_term         = '{valid: i_go, kind: i_kind, data: pat[7:0]};
  assign o_ext_line_dcc = pat[15:8];
  assign o_ext_toh      = pat[23:16];
endmodule
`default_nettype wire

// >>> tx_overhead_select_alarm_insert_tb.sv
// self-checking bench for transmit overhead select and alarm insert
// assumes the far-end model file and the design package are compiled first
`timescale 1ns/1ns
`default_nettype none
module tx_overhead_select_alarm_insert_tb;
  logic                   i_clk, i_rst, psel, penable, pwrite, go;
  logic [7:0]             paddr, ext_dcc, ext_toh, t, ed, et, o;
  logic [31:0]            pwdata, prdata, rnd, src, ins, dcc;
  logic                   pready, pslverr, pin_n, fifo_err, exc_b2, ring_rdi;
  logic                   b2_v, ring_v, term_alm, term_e1, rx_anom, j0_mis;
  logic [3:0]             b2_c, ring_c;
  tx_ohsel_pkg::slot_t    kind;
  tx_ohsel_pkg::tx_slot_t term, line;
  int                     bad_count, tests_run, cyc;

  tx_overhead_select_alarm_insert i_tx_overhead_select_alarm_insert (
    .i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_term(term), .i_ext_line_dcc(ext_dcc), .i_ext_toh(ext_toh),
    .i_alarm_input_pin_n(pin_n), .i_terminal_alarm(term_alm),
    .i_terminal_e1_alarm(term_e1), .i_fifo_error(fifo_err),
    .i_rx_line_anomaly(rx_anom), .i_excess_b2_error_rate(exc_b2),
    .i_section_trace_mismatch(j0_mis), .i_ring_rdi_req(ring_rdi),
    .i_b2_err_valid(b2_v), .i_b2_err_count(b2_c),
    .i_ring_febe_valid(ring_v), .i_ring_febe_count(ring_c), .o_line(line));
  tx_term_far_end i_tx_term_far_end (.i_clk(i_clk), .i_rst(i_rst),
    .i_go(go), .i_kind(kind), .o_term(term), .o_ext_line_dcc(ext_dcc),
    .o_ext_toh(ext_toh));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // expected byte of a slot with no maintenance overwrite active
  function automatic logic [7:0] sel(input logic [3:0] k);
    case (k)
      4'h1: return !(src[0] | src[1]) ? t : !src[2] ? dcc[7:0] :
                   (src[4] & !src[3]) ? et : ed;
      4'h2: return !(src[0] | src[5]) ? t : (!src[6] | src[4]) ? ins[7:0] : et;
      4'h3: return !(src[0] | src[7]) ? t : (!src[8] | src[4]) ? ins[15:8] : et;
      4'h4: return !(src[0] | src[9]) ? t : !src[10] ? ins[23:16] : et;
      4'h5: return !(src[0] | src[11]) ? t : !src[12] ? ins[31:24] : et;
      default: return t;
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] xd, input logic xe);
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    // only the bench timeout ends a wait for ready
    do begin
      @(posedge i_clk);
    end while (pready !== 1'b1);
    if (!w && !xe)
      check(prdata, xd);
    check(32'(pslverr), 32'(xe));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic slot(input logic [3:0] k);
    @(posedge i_clk);
    go <= 1'b1;
    kind <= tx_ohsel_pkg::slot_t'(k);
    #1;
    t = term.data;
    ed = ext_dcc;
    et = ext_toh;
    @(posedge i_clk);
    go <= 1'b0;
    #1;
    o = line.data;
    check(32'({line.valid, line.kind}), 32'({1'b1, k}));
  endtask

  task automatic rdi(input logic [31:0] alm, input logic exc, input logic ring,
                     input logic on);
    apb(1'b1, 8'h04, alm, 32'h0, 1'b0);
    exc_b2 <= exc;
    ring_rdi <= ring;
    slot(4'h6);
    check(32'(o[2:0]), on ? 32'h6 : 32'(t[2:0]));
  endtask

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      print_verdict();
    end
  end

  initial begin
    {i_rst, psel, penable, pwrite, go, fifo_err, exc_b2, ring_rdi} = 8'hff;
    {psel, penable, pwrite, go, fifo_err, exc_b2, ring_rdi} = 7'h00;
    {b2_v, ring_v, b2_c, ring_c, paddr, pwdata} = 50'h0;
    {term_alm, term_e1, rx_anom, j0_mis} = 4'h0;
    pin_n = 1'b1;
    kind = tx_ohsel_pkg::K_SOH;
    rnd = 32'hafb5;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    for (int a = 0; a < 24; a += 4)
      apb(1'b0, 8'(a), 32'h0, 32'h0, 1'b0);
    apb(1'b0, 8'h18, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h10, 32'h1, 32'h0, 1'b1);
    done("registers");
    for (int i = 0; i < 12; i++) begin
      rnd = xs(rnd);
      src = (i == 0) ? 32'h0 : (i == 1) ? 32'h1fff : rnd & 32'h1fff;
      rnd = xs(rnd);
      ins = rnd;
      rnd = xs(rnd);
      dcc = rnd & 32'hff;
      apb(1'b1, 8'h00, src, 32'h0, 1'b0);
      apb(1'b1, 8'h08, ins, 32'h0, 1'b0);
      apb(1'b1, 8'h0c, dcc, 32'h0, 1'b0);
      apb(1'b0, 8'h00, 32'h0, src, 1'b0);
      for (int k = 0; k < 6; k++) begin
        slot(4'(k));
        check(32'(o), 32'(sel(4'(k))));
      end
    end
    src = 32'h0;
    apb(1'b1, 8'h00, 32'h0, 32'h0, 1'b0);
    done("selection");
    apb(1'b1, 8'h04, 32'h1, 32'h0, 1'b0);
    b2_v <= 1'b1;
    b2_c <= 4'h3;
    @(posedge i_clk);
    b2_v <= 1'b0;
    slot(4'h3);
    check(32'(o), 32'({t[7:4], 4'h3}));
    apb(1'b1, 8'h04, 32'h3, 32'h0, 1'b0);
    {ring_v, ring_c, b2_v, b2_c} <= 10'h3a5;
    @(posedge i_clk);
    {ring_v, b2_v} <= 2'b00;
    slot(4'h3);
    check(32'(o[3:0]), 32'h8);
    slot(4'h3);
    check(32'(o[3:0]), 32'h5);
    done("far-end count");
    apb(1'b1, 8'h04, 32'h58, 32'h0, 1'b0);
    slot(4'ha);
    check(32'(o), 32'hff);
    slot(4'h9);
    check(32'(o), 32'hff);
    slot(4'h7);
    check(32'(o), 32'hff);
    apb(1'b1, 8'h04, 32'h18, 32'h0, 1'b0);
    slot(4'h7);
    check(32'(o[7:4]), 32'h9);
    slot(4'h7);
    check(32'(o[7:4]), 32'h6);
    apb(1'b1, 8'h04, 32'ha8, 32'h0, 1'b0);
    fifo_err <= 1'b1;
    slot(4'ha);
    check(32'(o), 32'hff);
    apb(1'b1, 8'h04, 32'h28, 32'h0, 1'b0);
    slot(4'ha);
    check(32'(o), 32'(t));
    fifo_err <= 1'b0;
    apb(1'b1, 8'h04, 32'h48, 32'h0, 1'b0);
    slot(4'ha);
    check(32'(o), 32'(t));
    apb(1'b0, 8'h10, 32'h0, 32'h2, 1'b0);
    apb(1'b1, 8'h04, 32'h318, 32'h0, 1'b0);
    term_e1 <= 1'b1;
    slot(4'ha);
    check(32'(o), 32'hff);
    apb(1'b1, 8'h04, 32'h118, 32'h0, 1'b0);
    slot(4'ha);
    check(32'(o), 32'(t));
    term_e1 <= 1'b0;
    term_alm <= 1'b1;
    slot(4'ha);
    check(32'(o), 32'hff);
    term_alm <= 1'b0;
    done("path ais");
    apb(1'b1, 8'h04, 32'h4408, 32'h0, 1'b0);
    slot(4'hb);
    check(32'(o), 32'hff);
    slot(4'h6);
    check(32'(o), 32'hff);
    slot(4'h0);
    check(32'(o), 32'(t));
    apb(1'b0, 8'h10, 32'h0, 32'h19, 1'b0);
    apb(1'b1, 8'h04, 32'h8008, 32'h0, 1'b0);
    pin_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    slot(4'hb);
    check(32'(o), 32'hff);
    pin_n <= 1'b1;
    term_alm <= 1'b1;
    repeat (4) @(posedge i_clk);
    slot(4'hb);
    check(32'(o), 32'hff);
    term_alm <= 1'b0;
    slot(4'hb);
    check(32'(o), 32'(t));
    apb(1'b1, 8'h04, 32'h4004, 32'h0, 1'b0);
    slot(4'h5);
    check(32'(o), 32'hff);
    apb(1'b0, 8'h10, 32'h0, 32'h1, 1'b0);
    apb(1'b1, 8'h04, 32'h4, 32'h0, 1'b0);
    slot(4'h5);
    check(32'(o), 32'h0);
    apb(1'b1, 8'h04, 32'h0, 32'h0, 1'b0);
    src = 32'h800;
    apb(1'b1, 8'h00, src, 32'h0, 1'b0);
    slot(4'h5);
    check(32'(o), 32'(ins[31:24]));
    done("line ais and e1");
    rdi(32'h400, 1'b0, 1'b0, 1'b1);
    rdi(32'h1800, 1'b1, 1'b0, 1'b1);
    rdi(32'h800, 1'b1, 1'b0, 1'b0);
    rdi(32'h0, 1'b0, 1'b1, 1'b1);
    rdi(32'h0, 1'b0, 1'b0, 1'b0);
    rx_anom <= 1'b1;
    rdi(32'h800, 1'b0, 1'b0, 1'b1);
    rx_anom <= 1'b0;
    j0_mis <= 1'b1;
    rdi(32'h2800, 1'b0, 1'b0, 1'b1);
    rdi(32'h800, 1'b0, 1'b0, 1'b0);
    j0_mis <= 1'b0;
    done("line rdi");
    print_verdict();
  end
endmodule
`default_nettype wire
